// File: rtl/lcs_pkg.sv
// Purpose: constants and types for the logic cell storage/control block
// Assumes: single clock ref_clk, synchronous active-high srst
// Notes: configuration bits arrive as plain ports, no register bus
package lcs_pkg;
   // data source select codes
   localparam logic [1:0] DSEL_F   = 2'h0;
   localparam logic [1:0] DSEL_G   = 2'h1;
   localparam logic [1:0] DSEL_H   = 2'h2;
   localparam logic [1:0] DSEL_DIN = 2'h3;
   // internal control signal indices
   localparam int CTL_EC  = 0;
   localparam int CTL_SR  = 1;
   localparam int CTL_DIN = 2;
   localparam int CTL_H1  = 3;
   localparam int NUM_CTL = 4;
   // value of an element after reset when configured as reset
   localparam logic RST_VAL_CLEAR = 1'b0;
   // cell operating modes
   typedef enum logic [1:0]
   {
      LCS_MODE_LOGIC   = 2'b00,
      LCS_MODE_MEM16   = 2'b01,
      LCS_MODE_MEM32   = 2'b10
   } lcs_mode_t;
endpackage : lcs_pkg

// File: rtl/lcs_elem.sv
// Purpose: one storage element of the cell
// Assumes: set/reset modelled synchronously to ref_clk, same-cycle effect on output path
// Notes: latch mode is emulated as transparent within the clock domain
`timescale 1ns/10ps
`default_nettype none
module lcs_elem
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   // configuration
   input  wire logic cfg_set,      // 1 = set element, 0 = reset element
   input  wire logic cfg_sr_en,    // local set/reset enabled
   input  wire logic cfg_latch,    // 1 = latch, 0 = flip-flop
   // operation
   input  wire logic global_init_net,
   input  wire logic local_set_reset_input,
   input  wire logic clock_gate_enable,
   input  wire logic d,
   output logic      q
);
   logic q_q;  // stored state
   logic q_d;  // next state
   logic init; // any active set/reset

   // next state: set/reset wins over capture and hold
   always_comb
   begin
      init = global_init_net | (cfg_sr_en & local_set_reset_input);
      q_d  = q_q;
      if (init)
         q_d = cfg_set;
      else if (clock_gate_enable)
         q_d = d;
   end

   // register; reset gives the configured start state, same bit as set/reset
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         q_q <= cfg_set ? ~lcs_pkg::RST_VAL_CLEAR : lcs_pkg::RST_VAL_CLEAR;
      else
         q_q <= q_d;
   end

   // latch mode passes next value through at once; set/reset also acts at once
   always_comb
   begin
      if (cfg_latch | init)
         q = q_d;
      else
         q = q_q;
   end
endmodule : lcs_elem
`default_nettype wire

// File: rtl/lcs_cell.sv
// Purpose: storage and control-input logic of one configurable logic cell
// Assumes: all inputs synchronous to ref_clk; configuration static during use
// Notes: srst stands for power-up/reconfiguration and drives the global init path
`timescale 1ns/10ps
`default_nettype none
module lcs_cell
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // global init net, already conditioned by user logic
   input  wire logic       global_init_net,
   // generic control inputs
   input  wire logic [3:0] generic_control_inputs,
   // function generator outputs
   input  wire logic       fgen_f_out,
   input  wire logic       fgen_g_out,
   input  wire logic       fgen_h_out,
   // configuration: control mapping, one 2-bit source per internal signal
   input  wire logic [7:0] cfg_ctl_map,
   input  wire logic [1:0] cfg_mode,
   // configuration: x element
   input  wire logic       cfg_x_set,
   input  wire logic       cfg_x_sr_en,
   input  wire logic       cfg_x_latch,
   input  wire logic [1:0] cfg_x_dsel,
   input  wire logic       cfg_x_bypass,
   input  wire logic [1:0] cfg_x_bypass_sel,
   // configuration: y element
   input  wire logic       cfg_y_set,
   input  wire logic       cfg_y_sr_en,
   input  wire logic       cfg_y_latch,
   input  wire logic [1:0] cfg_y_dsel,
   input  wire logic       cfg_y_bypass,
   input  wire logic [1:0] cfg_y_bypass_sel,
   // registered outputs
   output logic            x_registered_out,
   output logic            y_registered_out,
   // internal control signals toward generators
   output logic            clock_gate_enable,
   output logic            third_gen_input_zero,
   output logic            third_gen_input_one,
   output logic            third_gen_input_two,
   output logic            mem_write_enable,
   output logic            memory_data_in_a,
   output logic            memory_data_in_b,
   output logic            mem_addr_bit4
);
   // pick one of the four generic inputs
   function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
      pick4 = v[s];
   endfunction : pick4

   // pick storage data source
   function automatic logic pick_data(input logic [1:0] s, input logic f, input logic g,
                                      input logic h, input logic din);
      unique case (s)
         lcs_pkg::DSEL_F: pick_data = f;
         lcs_pkg::DSEL_G: pick_data = g;
         lcs_pkg::DSEL_H: pick_data = h;
         default:         pick_data = din;
      endcase
   endfunction : pick_data

   logic [lcs_pkg::NUM_CTL-1:0] ctl;        // internal control signals
   logic                        logic_mode; // logic function active
   logic                        mem32;      // 32x1 memory arrangement
   logic                        sr_eff;     // local set/reset as seen by elements
   logic                        ec_eff;     // enable seen by elements
   logic                        init_any;   // global init or reset
   logic                        x_d;        // x element data
   logic                        y_d;        // y element data
   logic                        x_q;        // x element state
   logic                        y_q;        // y element state
   // output flops
   logic xo_q, xo_d, yo_q, yo_d;
   logic ec_q, h0_q, h1_q, h2_q, we_q, da_q, db_q, a4_q;
   logic ec_d, h0_d, h1_d, h2_d, we_d, da_d, db_d, a4_d;

   // control steering: any generic input to any internal signal
   always_comb
   begin
      for (int i = 0; i < lcs_pkg::NUM_CTL; i++)
         ctl[i] = pick4(generic_control_inputs, cfg_ctl_map[2*i +: 2]);
      logic_mode = (lcs_pkg::lcs_mode_t'(cfg_mode) == lcs_pkg::LCS_MODE_LOGIC);
      mem32      = (lcs_pkg::lcs_mode_t'(cfg_mode) == lcs_pkg::LCS_MODE_MEM32);
      // in memory mode the set/reset slot becomes write enable, so no local reset
      sr_eff     = logic_mode & ctl[lcs_pkg::CTL_SR];
      ec_eff     = ctl[lcs_pkg::CTL_EC];
      init_any   = global_init_net | srst;
      x_d = pick_data(cfg_x_dsel, fgen_f_out, fgen_g_out, fgen_h_out, ctl[lcs_pkg::CTL_DIN]);
      y_d = pick_data(cfg_y_dsel, fgen_f_out, fgen_g_out, fgen_h_out, ctl[lcs_pkg::CTL_DIN]);
   end

   // x storage element
   lcs_elem u_x
   (
      .ref_clk               (ref_clk),
      .srst                  (srst),
      .cfg_set               (cfg_x_set),
      .cfg_sr_en             (cfg_x_sr_en),
      .cfg_latch             (cfg_x_latch),
      .global_init_net       (init_any),
      .local_set_reset_input (sr_eff),
      .clock_gate_enable     (ec_eff),
      .d                     (x_d),
      .q                     (x_q)
   );

   // y storage element
   lcs_elem u_y
   (
      .ref_clk               (ref_clk),
      .srst                  (srst),
      .cfg_set               (cfg_y_set),
      .cfg_sr_en             (cfg_y_sr_en),
      .cfg_latch             (cfg_y_latch),
      .global_init_net       (init_any),
      .local_set_reset_input (sr_eff),
      .clock_gate_enable     (ec_eff),
      .d                     (y_d),
      .q                     (y_q)
   );

   // output selectors and mode decode of the internal control signals
   always_comb
   begin
      xo_d = cfg_x_bypass ? pick4(generic_control_inputs, cfg_x_bypass_sel) : x_q;
      yo_d = cfg_y_bypass ? pick4(generic_control_inputs, cfg_y_bypass_sel) : y_q;
      ec_d = ctl[lcs_pkg::CTL_EC];
      // logic mode meanings
      h0_d = logic_mode & ctl[lcs_pkg::CTL_SR];
      h2_d = logic_mode & ctl[lcs_pkg::CTL_DIN];
      h1_d = logic_mode & ctl[lcs_pkg::CTL_H1];
      // memory mode meanings
      we_d = ~logic_mode & ctl[lcs_pkg::CTL_SR];
      da_d = ~logic_mode & ctl[lcs_pkg::CTL_DIN];
      db_d = ~logic_mode & ~mem32 & ctl[lcs_pkg::CTL_H1];
      a4_d = mem32 & ctl[lcs_pkg::CTL_H1];
   end

   // output registers; they add one cycle so every output is a flop
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         xo_q <= 1'b0;
         yo_q <= 1'b0;
         ec_q <= 1'b0;
         h0_q <= 1'b0;
         h1_q <= 1'b0;
         h2_q <= 1'b0;
         we_q <= 1'b0;
         da_q <= 1'b0;
         db_q <= 1'b0;
         a4_q <= 1'b0;
      end
      else
      begin
         xo_q <= xo_d;
         yo_q <= yo_d;
         ec_q <= ec_d;
         h0_q <= h0_d;
         h1_q <= h1_d;
         h2_q <= h2_d;
         we_q <= we_d;
         da_q <= da_d;
         db_q <= db_d;
         a4_q <= a4_d;
      end
   end

   assign x_registered_out     = xo_q;
   assign y_registered_out     = yo_q;
   assign clock_gate_enable    = ec_q;
   assign third_gen_input_zero = h0_q;
   assign third_gen_input_one  = h1_q;
   assign third_gen_input_two  = h2_q;
   assign mem_write_enable     = we_q;
   assign memory_data_in_a     = da_q;
   assign memory_data_in_b     = db_q;
   assign mem_addr_bit4        = a4_q;
endmodule : lcs_cell
`default_nettype wire

// File: tb/lcs_fabric.sv
// Purpose: routing model in front of the cell. Assumes: one pad feeds the global init net. Notes: combinational.
`timescale 1ns/10ps
`default_nettype none
module lcs_fabric
#(
   parameter logic INIT_INV = 1'b1  // inverter after the pad buffer
)
(
   // pad and dedicated net
   input  wire logic init_pad_n,
   output logic      global_init_net
);
   // pad reaches the net through an optional inverter, so either pad sense works
   assign global_init_net = init_pad_n ^ INIT_INV;
endmodule : lcs_fabric
`default_nettype wire

// File: tb/lcs_cell_assertions.sv
// Purpose: port checks of lcs_cell. Assumes: ref_clk only, sync srst. Notes: config static per test.
`timescale 1ns/10ps
`default_nettype none
module lcs_cell_assertions
(
   // clock, reset, drive and config
   input wire logic       ref_clk, srst, global_init_net, fgen_f_out, fgen_g_out, fgen_h_out,
   input wire logic [3:0] generic_control_inputs,
   input wire logic [7:0] cfg_ctl_map,
   input wire logic [1:0] cfg_mode, cfg_x_dsel, cfg_y_bypass_sel,
   input wire logic       cfg_x_set, cfg_x_sr_en, cfg_x_latch, cfg_x_bypass, cfg_y_set, cfg_y_sr_en, cfg_y_bypass,
   // watched outputs
   input wire logic       x_registered_out, y_registered_out, clock_gate_enable, third_gen_input_zero,
   input wire logic       mem_write_enable, memory_data_in_b, mem_addr_bit4
);
   // expected selector outputs and element conditions
   wire logic [3:0] gi  = generic_control_inputs;
   wire logic [7:0] m   = cfg_ctl_map;
   wire logic [3:0] ctl = {gi[m[7:6]], gi[m[5:4]], gi[m[3:2]], gi[m[1:0]]};
   wire logic       lg  = cfg_mode == 2'h0; // local set/reset only lives in logic mode
   wire logic       srx = global_init_net | (lg & cfg_x_sr_en & ctl[1]);
   wire logic       sry = global_init_net | (lg & cfg_y_sr_en & ctl[1]);
   wire logic [3:0] ds  = {ctl[2], fgen_h_out, fgen_g_out, fgen_f_out};
   wire logic       dx  = ds[cfg_x_dsel];
   wire logic       hx  = !srst & !srx & !ctl[0] & !cfg_x_bypass & !cfg_x_latch; // x must hold
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   ce_route_a: assert property (!$past(srst) |-> clock_gate_enable == $past(ctl[0]))
      else $error("enable route wrong");
   h0_logic_a: assert property (!$past(srst) && $past(lg) |-> third_gen_input_zero == $past(ctl[1]) && !mem_write_enable)
      else $error("logic mode control wrong");
   we_mem_a: assert property (!$past(srst) && !$past(lg) |-> mem_write_enable == $past(ctl[1]) && !third_gen_input_zero)
      else $error("write enable wrong");
   addr4_a: assert property (!$past(srst) && $past(cfg_mode) == 2'h2 |-> mem_addr_bit4 == $past(ctl[3]) && !memory_data_in_b)
      else $error("address bit wrong");
   x_init_a: assert property (!srst && srx && !cfg_x_bypass |=> x_registered_out == cfg_x_set)
      else $error("x set/reset state wrong");
   y_local_a: assert property (!srst && sry && !cfg_y_bypass |=> y_registered_out == cfg_y_set)
      else $error("y set/reset state wrong");
   x_hold_a: assert property (hx ##1 hx |=> $stable(x_registered_out))
      else $error("x did not hold");
   x_capture_a: assert property (!srst && !srx && !cfg_x_latch && !cfg_x_bypass && ctl[0]
      ##1 (!srst && !srx && !cfg_x_latch && !cfg_x_bypass) |=> x_registered_out == $past(dx, 2)) else $error("x capture wrong");
   x_latch_a: assert property (!srst && !srx && cfg_x_latch && !cfg_x_bypass && ctl[0] |=> x_registered_out == $past(dx))
      else $error("x latch not transparent");
   y_bypass_a: assert property (!srst && !sry && cfg_y_bypass |=> y_registered_out == $past(gi[cfg_y_bypass_sel]))
      else $error("y bypass wrong");
   // main scenarios reached
   c_global: cover property (global_init_net);
   c_local: cover property (lg && cfg_x_sr_en && ctl[1]);
   c_mem32: cover property (cfg_mode == 2'h2);
endmodule : lcs_cell_assertions
bind lcs_cell lcs_cell_assertions u_chk (.*);
`default_nettype wire

// File: tb/lcs_cell_tb.sv
// Purpose: directed bench for lcs_cell. Assumes: 40 MHz ref_clk. Notes: config changes only between drives.
`timescale 1ns/10ps
`default_nettype none
module lcs_cell_tb;
   // stimulus and observed signals, named as the cell ports
   logic       ref_clk, srst, init_pad_n, fgen_f_out, fgen_g_out, fgen_h_out, global_init_net;
   logic [3:0] generic_control_inputs;
   logic [7:0] cfg_ctl_map;
   logic [1:0] cfg_mode, cfg_x_dsel, cfg_y_dsel, cfg_x_bypass_sel, cfg_y_bypass_sel;
   logic       cfg_x_set, cfg_x_sr_en, cfg_x_latch, cfg_x_bypass, cfg_y_set, cfg_y_sr_en, cfg_y_latch, cfg_y_bypass;
   logic       x_registered_out, y_registered_out, clock_gate_enable, third_gen_input_zero, third_gen_input_one;
   logic       third_gen_input_two, mem_write_enable, memory_data_in_a, memory_data_in_b, mem_addr_bit4;
   logic [3:0] ctl; // expected internal controls
   int         err_count, tests_run, cycles;
   lcs_fabric u_fab (.init_pad_n, .global_init_net);
   lcs_cell u_dut (.*);
   // free-running clock
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // hang guard, a few times the expected run length
   always @(posedge ref_clk)
      if (++cycles == 1000) close_out(1'b1);
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   // drive at an edge, hold two more edges, then look after the outputs settle
   task automatic drive(input logic [3:0] g, input logic p = 1'b1, input logic [2:0] d = 3'h0);
      tick(1);
      generic_control_inputs <= g;
      init_pad_n <= p;
      {fgen_f_out, fgen_g_out, fgen_h_out} <= d;
      tick(2);
      #1;
   endtask : drive
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out(input bit hung);
      if (hung)
         err_count++;
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   // test sequence; identity map puts input i on internal control i
   initial
   begin
      srst = 1'b1;
      {init_pad_n, fgen_f_out, fgen_g_out, fgen_h_out, generic_control_inputs} = 8'h80;
      {cfg_ctl_map, cfg_mode, cfg_x_dsel, cfg_y_dsel, cfg_x_bypass_sel, cfg_y_bypass_sel} = 18'h39010;
      {cfg_x_set, cfg_x_sr_en, cfg_x_latch, cfg_x_bypass} = 4'h8;
      {cfg_y_set, cfg_y_sr_en, cfg_y_latch, cfg_y_bypass} = 4'h0;
      tick(12);
      srst <= 1'b0;
      tick(2);
      #1 chk({x_registered_out, y_registered_out}, 8'h2);
      $display("test start-up state done");
      drive(4'h1, 1'b1, 3'h2);
      drive(4'h0);
      chk({x_registered_out, y_registered_out}, 8'h1);
      cfg_x_sr_en <= 1'b1;
      drive(4'h2);
      drive(4'h0);
      chk({x_registered_out, y_registered_out}, 8'h3);
      drive(4'h0, 1'b0);
      drive(4'h0);
      chk({x_registered_out, y_registered_out}, 8'h2);
      $display("test capture and set/reset done");
      cfg_x_sr_en <= 1'b0;
      for (int s = 0; s < 4; s++)
      begin
         cfg_x_dsel <= 2'(s);
         drive((s == 3) ? 4'h5 : 4'h1, 1'b1, 3'(4 >> s));
         drive(4'h0);
         chk(x_registered_out, 8'h1);
         drive(4'h1);
         chk(x_registered_out, 8'h0);
      end
      $display("test data source done");
      cfg_x_dsel <= 2'h0;
      cfg_x_latch <= 1'b1;
      tick(1);
      generic_control_inputs <= 4'h1;
      fgen_f_out <= 1'b1;
      tick(1);
      #1 chk(x_registered_out, 8'h1);
      drive(4'h0);
      chk(x_registered_out, 8'h1);
      $display("test latch done");
      cfg_y_bypass <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         cfg_y_bypass_sel <= 2'(s);
         drive(4'h1 << s);
         chk(y_registered_out, 8'h1);
         drive(~(4'h1 << s));
         chk(y_registered_out, 8'h0);
      end
      $display("test bypass done");
      for (int m = 0; m < 4; m++)
         for (int r = 0; r < 4; r++)
         begin
            cfg_mode <= 2'(m);
            cfg_ctl_map <= {2'(r + 3), 2'(r + 2), 2'(r + 1), 2'(r)};
            ctl = 4'(8'h66 >> r);
            drive(4'h6);
            chk({clock_gate_enable, third_gen_input_one, third_gen_input_two, third_gen_input_zero,
                 mem_addr_bit4, memory_data_in_b, memory_data_in_a, mem_write_enable},
                {ctl[0], (m == 0) ? ctl[3:1] : 3'h0, ctl[3] & (m == 2), ctl[3] & (m == 1 || m == 3),
                 (m != 0) ? ctl[2:1] : 2'h0});
         end
      $display("test control map done");
      close_out(1'b0);
   end
endmodule : lcs_cell_tb
`default_nettype wire
